/* hw/hbcs_pkg.sv */
// hbcs_pkg: constants and stage codes of the hub boot sequencer
// assumes a 100 MHz sys_clk; pads present straps as sensed level codes
package hbcs_pkg;

    // ========================================
    // spi timing, 8 sys cycles per sck
    localparam logic [2:0]  SCK_RISE_PH  = 3'h4;
    localparam logic [2:0]  SCK_LAST_PH  = 3'h7;

    // ========================================
    // spi rom probe
    localparam logic [7:0]  CMD_READ     = 8'h03;
    localparam logic [7:0]  CMD_DUAL     = 8'h3B;
    localparam logic [23:0] SIG_ADDR     = 24'h00_FFFA;
    localparam logic [31:0] SIG_VALUE    = 32'h3244_4655;  // "2DFU"
    localparam logic [15:0] EXEC_ADDR    = 16'h0000;
    localparam logic [6:0]  TX_BITS      = 7'h20;
    localparam logic [6:0]  RX_START_1X  = 7'h20;
    localparam logic [6:0]  RX_START_2X  = 7'h28;          // 8 dummy clocks in dual read
    localparam logic [6:0]  END_1X       = 7'h40;
    localparam logic [6:0]  END_2X       = 7'h38;

    // ========================================
    // soc session end register
    localparam logic [7:0]  SOC_END_REG  = 8'hFF;

    // ========================================
    // five-level strap: sensed level codes
    localparam logic [2:0]  LVL_PD_200K  = 3'h0;
    localparam logic [2:0]  LVL_PU_200K  = 3'h1;
    localparam logic [2:0]  LVL_PD_10K   = 3'h2;
    localparam logic [2:0]  LVL_PU_10K   = 3'h3;
    localparam logic [2:0]  LVL_PD_10R   = 3'h4;
    localparam int unsigned PORTS        = 4;

    // ========================================
    // pin synchroniser width
    localparam int unsigned PIN_W        = 16;

    // ========================================
    // boot stages
    typedef enum logic [3:0] {
        HBCS_STANDBY, HBCS_ROM_PROBE, HBCS_DEF_LOAD, HBCS_PIN_SAMPLE,
        HBCS_SOC_SETUP, HBCS_MERGE, HBCS_IDLE, HBCS_SUSPEND,
        HBCS_CHARGER_DETECT, HBCS_ATTACH, HBCS_NORMAL
    } hbcs_stage_t;

endpackage : hbcs_pkg

/* hw/hbcs_sync.sv */
// hbcs_sync: two-flop synchroniser for independent pin levels
// assumes each bit is a level that may change at any time
`timescale 1ns/10ps
module hbcs_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         sys_clk,  // core clock
    input  wire logic         arst_n,   // async reset, active low
    input  wire logic [W-1:0] pin_in,   // raw pin levels
    output logic      [W-1:0] pin_sync  // levels after two flops
);

    logic [W-1:0] meta;

    // ========================================
    // first flop feeds only the second
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta     <= '0;
            pin_sync <= '0;
        end else begin
            meta     <= pin_in;
            pin_sync <= meta;
        end
    end

endmodule : hbcs_sync

/* hw/hbcs_strap_decode.sv */
// hbcs_strap_decode: five-level resistor strap to port count and port mask
// assumes a synchronised, latched level code from the pad sense logic
`timescale 1ns/10ps
module hbcs_strap_decode (
    input  wire logic [2:0] level,      // sensed level code
    output logic      [2:0] port_count, // ports affected, counted from port 1
    output logic      [3:0] port_mask   // one bit per port, bit 0 is port 1
);

    // ========================================
    // unknown codes fall back to no ports, the safe choice
    always_comb begin
        unique case (level)
            hbcs_pkg::LVL_PU_200K: port_count = 3'h1;
            hbcs_pkg::LVL_PD_10K:  port_count = 3'h2;
            hbcs_pkg::LVL_PU_10K:  port_count = 3'h3;
            hbcs_pkg::LVL_PD_10R:  port_count = 3'h4;
            default:               port_count = 3'h0;
        endcase
        for (int i = 0; i < hbcs_pkg::PORTS; i++) begin
            port_mask[i] = (32'(port_count) > i);
        end
    end

endmodule : hbcs_strap_decode

/* hw/hbcs_top.sv */
// hbcs_top: boot and configuration sequencer of a four-port hub
// assumes load, merge and charger handshakes on sys_clk
// and raw pins from outside the domain
//
// Operation
// - fixed-port strap decodes to five settings
// - charge strap decodes to five settings
// - reset pin low standby, high hub
// - standby: ports off, pins hi-z, pll halted
// - nothing kept across standby, reinit after
// - reset release enters rom probe, defaults
// - probe spi flash for 2DFU at FFFA
// - match sets external rom, both then default load
// - no spi strap skips external rom
// - spi single/dual bit, mode 0 frames, mode 3 parks sck high after
// - load defaults, then strap overrides
// - sample spi straps, pick soc or merge
// - soc setup waits without any timeout
// - soc write to register FF ends setup
// - merge default, soc and otp, apply
// - configured: idle, then suspend without vbus and connect_req
// - vbus: charger detect if charging, else attach
// - charger detect done leads to attach
// - attach connects on vbus, holds till drop
// - latch all straps at reset release
// - both pull-ups smbus, no pulls spi
// - reset low standby, soft disconnect attach
`timescale 1ns/10ps
module hbcs_top (
    input  wire logic        sys_clk,        // 100 MHz core clock
    input  wire logic        arst_n,         // power-on reset, active low
    input  wire logic        chip_reset_n,   // chip reset pin, active low
    input  wire logic [2:0]  fixed_port_strap,  // fixed-port strap level
    input  wire logic [2:0]  charge_port_strap, // charge strap level
    input  wire logic        sdo_pullup,     // 10k pull-up on spi data-out
    input  wire logic        sck_pullup,     // 10k pull-up on spi clock
    input  wire logic        sdo_pulled,     // any pull on spi data-out
    input  wire logic        sck_pulled,     // any pull on spi clock
    input  wire logic        spi_dual,       // 1: dual-bit rom read
    input  wire logic        spi_mode3,      // 1: sck parked high after the probe frame, low before it
    input  wire logic        spi_di,         // spi data in pin
    input  wire logic        spi_do_in,      // spi data-out, read in dual
    input  wire logic        vbus,           // vbus function pin
    input  wire logic        connect_req,    // hub connect request pin
    input  wire logic        soft_disc,      // upstream soft disconnect
    input  wire logic        usb_configured, // host finished enumeration
    input  wire logic        load_done,      // default load finished
    input  wire logic        soc_wr,         // smbus write strobe
    input  wire logic [7:0]  soc_wr_reg,     // smbus write register
    input  wire logic        merge_done,     // merge and apply finished
    input  wire logic        chg_done,       // charger detection finished
    output logic             spi_ce_n,       // spi chip enable, active low
    output logic             spi_sck,        // spi serial clock
    output logic             spi_do,         // spi data out
    output logic             spi_do_oe,      // spi data-out drive enable
    output logic             ext_rom_en,     // executing from external rom
    output logic [15:0]      exec_addr,      // start address of execution
    output logic             load_req,       // default load request
    output logic [3:0]       fixed_ports,    // non-removable port mask
    output logic [3:0]       charge_ports,   // charging port mask
    output logic [2:0]       fixed_count,    // non-removable port count
    output logic [2:0]       charge_count,   // charging port count
    output logic             smbus_mode,     // smbus slave mode selected
    output logic             soc_cfg_en,     // soc writes accepted
    output logic             merge_req,      // merge request
    output logic             chg_req,        // charger detect request
    output logic             suspended,      // hub in suspend
    output logic             usb_connect,    // upstream connect
    output logic [3:0]       ports_en,       // downstream port enables
    output logic             phy_oe,         // data pins driven, low is hi-z
    output logic             pll_run,        // pll enabled
    output logic [3:0]       stage           // current boot stage code
);

    // ========================================
    // state
    typedef struct packed {
        hbcs_pkg::hbcs_stage_t st;
        logic [2:0]  ph;
        logic [6:0]  bitn;
        logic [31:0] tx;
        logic [31:0] rx;
        logic        busy;
        logic [2:0]  fix_lvl;
        logic [2:0]  chg_lvl;
        logic        smb;
        logic        spi_sel;
        logic        dual;
        logic        mode3;
        logic        spi_ce_n;
        logic        spi_sck;
        logic        spi_do;
        logic        spi_do_oe;
        logic        ext_rom_en;
        logic [15:0] exec_addr;
        logic        load_req;
        logic [3:0]  fixed_ports;
        logic [3:0]  charge_ports;
        logic [2:0]  fixed_count;
        logic [2:0]  charge_count;
        logic        soc_cfg_en;
        logic        merge_req;
        logic        chg_req;
        logic        suspended;
        logic        usb_connect;
        logic [3:0]  ports_en;
        logic        phy_oe;
        logic        pll_run;
    } hbcs_state_t;

    hbcs_state_t s;
    hbcs_state_t next_s;

    // ========================================
    // pin synchronisers
    logic [hbcs_pkg::PIN_W-1:0] pins_raw;
    logic [hbcs_pkg::PIN_W-1:0] pins;
    assign pins_raw = {chip_reset_n, fixed_port_strap, charge_port_strap, sdo_pullup,
                       sck_pullup, sdo_pulled, sck_pulled, spi_di, spi_do_in, vbus,
                       connect_req, soft_disc};

    hbcs_sync #(.W(hbcs_pkg::PIN_W)) u_sync (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .pin_in   (pins_raw),
        .pin_sync (pins)
    );

    logic       rst_pin_s;
    logic [2:0] fix_s;
    logic [2:0] chg_s;
    logic       sdo_pu_s;
    logic       sck_pu_s;
    logic       sdo_any_s;
    logic       sck_any_s;
    logic       di_s;
    logic       do_s;
    logic       vbus_s;
    logic       conn_s;
    logic       disc_s;
    assign {rst_pin_s, fix_s, chg_s, sdo_pu_s, sck_pu_s, sdo_any_s, sck_any_s,
            di_s, do_s, vbus_s, conn_s, disc_s} = pins;

    // ========================================
    // strap decoders, fed from the latched levels
    logic [2:0] fix_cnt;
    logic [3:0] fix_mask;
    logic [2:0] chg_cnt;
    logic [3:0] chg_mask;

    hbcs_strap_decode u_fix_dec (
        .level      (s.fix_lvl),
        .port_count (fix_cnt),
        .port_mask  (fix_mask)
    );

    hbcs_strap_decode u_chg_dec (
        .level      (s.chg_lvl),
        .port_count (chg_cnt),
        .port_mask  (chg_mask)
    );

    // ========================================
    // spi probe helpers
    logic [6:0] rx_start;
    logic [6:0] end_bit;
    logic       rx_phase;
    assign rx_start = s.dual ? hbcs_pkg::RX_START_2X : hbcs_pkg::RX_START_1X;
    assign end_bit  = s.dual ? hbcs_pkg::END_2X : hbcs_pkg::END_1X;
    assign rx_phase = (s.bitn >= rx_start);

    // ========================================
    // sequencer; reset pin low overrides every stage
    always_comb begin
        next_s = s;
        unique case (s.st)
            hbcs_pkg::HBCS_STANDBY: begin
                if (rst_pin_s) begin
                    next_s.fix_lvl = fix_s;
                    next_s.chg_lvl = chg_s;
                    next_s.smb     = sdo_pu_s && sck_pu_s;
                    next_s.spi_sel = !sdo_any_s && !sck_any_s;
                    next_s.dual    = spi_dual;
                    next_s.mode3   = spi_mode3;
                    next_s.pll_run = 1'b1;
                    next_s.st      = hbcs_pkg::HBCS_ROM_PROBE;
                end
            end
            hbcs_pkg::HBCS_ROM_PROBE: begin
                if (!s.spi_sel) begin
                    next_s.st = hbcs_pkg::HBCS_DEF_LOAD;
                end else if (!s.busy) begin
                    // start the signature read
                    next_s.busy     = 1'b1;
                    next_s.spi_ce_n = 1'b0;
                    next_s.ph       = '0;
                    next_s.bitn     = '0;
                    next_s.tx       = {s.dual ? hbcs_pkg::CMD_DUAL : hbcs_pkg::CMD_READ,
                                       hbcs_pkg::SIG_ADDR};
                    next_s.rx       = '0;
                    next_s.spi_do   = 1'b0;
                    next_s.spi_do_oe = 1'b1;
                end else begin
                    next_s.ph      = s.ph + 3'h1;
                    next_s.spi_sck = (s.ph + 3'h1) >= hbcs_pkg::SCK_RISE_PH;
                    if (s.ph == '0) begin
                        // launch on the falling half, rom samples on the rise
                        next_s.spi_do    = s.tx[31];
                        next_s.spi_do_oe = !s.dual || (s.bitn < hbcs_pkg::TX_BITS);
                    end
                    if (s.ph == hbcs_pkg::SCK_LAST_PH) begin
                        next_s.spi_sck = 1'b0;
                        next_s.tx      = {s.tx[30:0], 1'b0};
                        next_s.bitn    = s.bitn + 7'h1;
                        if (rx_phase) begin
                            // late sample: synchroniser delay stays inside one half period
                            next_s.rx = s.dual ? {s.rx[29:0], di_s, do_s} : {s.rx[30:0], di_s};
                        end
                        if (s.bitn + 7'h1 == end_bit) begin
                            next_s.busy      = 1'b0;
                            next_s.spi_ce_n  = 1'b1;
                            next_s.spi_do_oe = 1'b0;
                            next_s.spi_sck   = s.mode3;
                            if ((s.dual ? {s.rx[29:0], di_s, do_s} : {s.rx[30:0], di_s})
                                == hbcs_pkg::SIG_VALUE) begin
                                next_s.ext_rom_en = 1'b1;
                                next_s.exec_addr  = hbcs_pkg::EXEC_ADDR;
                            end
                            next_s.st = hbcs_pkg::HBCS_DEF_LOAD;
                        end
                    end
                end
            end
            hbcs_pkg::HBCS_DEF_LOAD: begin
                next_s.load_req = 1'b1;
                if (s.load_req && load_done) begin
                    // strap values override the rom defaults
                    next_s.load_req     = 1'b0;
                    next_s.fixed_ports  = fix_mask;
                    next_s.charge_ports = chg_mask;
                    next_s.fixed_count  = fix_cnt;
                    next_s.charge_count = chg_cnt;
                    next_s.st           = hbcs_pkg::HBCS_PIN_SAMPLE;
                end
            end
            hbcs_pkg::HBCS_PIN_SAMPLE: begin
                if (s.smb) begin
                    next_s.soc_cfg_en = 1'b1;
                    next_s.st         = hbcs_pkg::HBCS_SOC_SETUP;
                end else begin
                    next_s.st = hbcs_pkg::HBCS_MERGE;
                end
            end
            hbcs_pkg::HBCS_SOC_SETUP: begin
                // no timeout: only the end-of-session write leaves
                if (soc_wr && soc_wr_reg == hbcs_pkg::SOC_END_REG) begin
                    next_s.soc_cfg_en = 1'b0;
                    next_s.st         = hbcs_pkg::HBCS_MERGE;
                end
            end
            hbcs_pkg::HBCS_MERGE: begin
                next_s.merge_req = 1'b1;
                if (s.merge_req && merge_done) begin
                    next_s.merge_req = 1'b0;
                    next_s.ports_en  = 4'hF;
                    next_s.phy_oe    = 1'b1;
                    next_s.st        = hbcs_pkg::HBCS_IDLE;
                end
            end
            hbcs_pkg::HBCS_IDLE, hbcs_pkg::HBCS_SUSPEND: begin
                next_s.suspended = 1'b0;
                if (vbus_s) begin
                    next_s.st = (s.charge_count != 3'h0) ? hbcs_pkg::HBCS_CHARGER_DETECT
                                                         : hbcs_pkg::HBCS_ATTACH;
                end else if (!conn_s) begin
                    next_s.suspended = 1'b1;
                    next_s.st        = hbcs_pkg::HBCS_SUSPEND;
                end else begin
                    next_s.st = hbcs_pkg::HBCS_IDLE;
                end
            end
            hbcs_pkg::HBCS_CHARGER_DETECT: begin
                next_s.chg_req = 1'b1;
                if (s.chg_req && chg_done) begin
                    next_s.chg_req = 1'b0;
                    next_s.st      = hbcs_pkg::HBCS_ATTACH;
                end
            end
            hbcs_pkg::HBCS_ATTACH: begin
                // connect while vbus high, no soft disconnect
                next_s.usb_connect = vbus_s && !disc_s;
                if (!vbus_s) begin
                    next_s.st = hbcs_pkg::HBCS_IDLE;
                end else if (usb_configured && !disc_s) begin
                    next_s.st = hbcs_pkg::HBCS_NORMAL;
                end
            end
            hbcs_pkg::HBCS_NORMAL: begin
                if (!vbus_s) begin
                    next_s.usb_connect = 1'b0;
                    next_s.st          = hbcs_pkg::HBCS_IDLE;
                end else if (disc_s) begin
                    next_s.usb_connect = 1'b0;
                    next_s.st          = hbcs_pkg::HBCS_ATTACH;
                end
            end
            default: begin
                next_s.st = hbcs_pkg::HBCS_STANDBY;
            end
        endcase

        // reset pin low: drop everything, nothing is saved
        if (!rst_pin_s) begin
            next_s          = '0;
            next_s.st       = hbcs_pkg::HBCS_STANDBY;
            next_s.spi_ce_n = 1'b1;
        end
    end

    // ========================================
    // state register; resets to idle standby
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s          <= '0;
            s.st       <= hbcs_pkg::HBCS_STANDBY;
            s.spi_ce_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ========================================
    // outputs straight from the state register
    assign spi_ce_n     = s.spi_ce_n;
    assign spi_sck      = s.spi_sck;
    assign spi_do       = s.spi_do;
    assign spi_do_oe    = s.spi_do_oe;
    assign ext_rom_en   = s.ext_rom_en;
    assign exec_addr    = s.exec_addr;
    assign load_req     = s.load_req;
    assign fixed_ports  = s.fixed_ports;
    assign charge_ports = s.charge_ports;
    assign fixed_count  = s.fixed_count;
    assign charge_count = s.charge_count;
    assign smbus_mode   = s.smb;
    assign soc_cfg_en   = s.soc_cfg_en;
    assign merge_req    = s.merge_req;
    assign chg_req      = s.chg_req;
    assign suspended    = s.suspended;
    assign usb_connect  = s.usb_connect;
    assign ports_en     = s.ports_en;
    assign phy_oe       = s.phy_oe;
    assign pll_run      = s.pll_run;
    assign stage        = s.st;

endmodule : hbcs_top

/* verif/hbcs_top_assertions.sv */
// hbcs_top_assertions: port-level checks of the boot sequencer
// assumes it is bound onto hbcs_top, single sys_clk domain
`timescale 1ns/10ps
module hbcs_top_assertions (
    input wire logic        sys_clk, arst_n, chip_reset_n, // clock and resets
    input wire logic        soc_wr, load_done, merge_done, chg_done, // inputs
    input wire logic [7:0]  soc_wr_reg, // register
    input wire logic        spi_ce_n, ext_rom_en, load_req, merge_req, // outputs
    input wire logic        chg_req, suspended, phy_oe, pll_run, // outputs
    input wire logic [15:0] exec_addr, // address
    input wire logic [3:0]  fixed_ports, charge_ports, ports_en, stage, // masks and stage code
    input wire logic [2:0]  fixed_count, charge_count // port counts
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ========================================
    // reset pin high through the synchroniser
    sequence hub_on;
        chip_reset_n && $past(chip_reset_n) && $past(chip_reset_n, 2);
    endsequence
    AST_STBY_OFF: assert property (stage == 4'h0 |-> !ports_en && !phy_oe && !pll_run && !ext_rom_en)
        else $error("standby outputs active");
    AST_RST_STBY: assert property (!chip_reset_n [*4] |-> stage == 4'h0 && spi_ce_n)
        else $error("reset pin low but not standby");
    AST_CE_PROBE: assert property (!spi_ce_n |-> stage == 4'h1 && pll_run)
        else $error("flash selected outside probe");
    AST_ROM_EN: assert property ($rose(ext_rom_en) |-> $past(stage) == 4'h1 && exec_addr == 16'h0000)
        else $error("external rom enable wrong");
    AST_LOAD: assert property (hub_on ##0 (stage == 4'h2 && load_req && load_done) |=> stage == 4'h3)
        else $error("default load did not end");
    AST_MASK: assert property (fixed_ports == 4'((5'h01 << fixed_count) - 5'h01))
        else $error("fixed mask and count disagree");
    AST_CMASK: assert property (charge_ports == 4'((5'h01 << charge_count) - 5'h01))
        else $error("charge mask and count disagree");
    AST_SOC_WAIT: assert property (hub_on ##0 (stage == 4'h4 && !(soc_wr && soc_wr_reg == 8'hFF)) |=> stage == 4'h4)
        else $error("soc setup left early");
    AST_SOC_END: assert property (hub_on ##0 (stage == 4'h4 && soc_wr && soc_wr_reg == 8'hFF) |=> stage == 4'h5)
        else $error("soc end write ignored");
    AST_MERGE: assert property (hub_on ##0 (stage == 4'h5 && merge_req && merge_done) |=> ports_en == 4'hF && phy_oe)
        else $error("merge did not apply");
    AST_SUSP: assert property (suspended == (stage == 4'h7))
        else $error("suspend flag wrong");
    AST_VBUS: assert property (stage inside {4'h6, 4'h7} ##1 stage inside {4'h8, 4'h9} |-> (stage == 4'h8) == (charge_count != 3'h0))
        else $error("vbus path wrong");
    AST_CHG: assert property (hub_on ##0 (stage == 4'h8 && chg_req && chg_done) |=> stage == 4'h9)
        else $error("charger detect did not end");
endmodule : hbcs_top_assertions
bind hbcs_top hbcs_top_assertions i_hbcs_top_assertions (.sys_clk(sys_clk), .arst_n(arst_n),
    .chip_reset_n(chip_reset_n), .soc_wr(soc_wr), .load_done(load_done), .merge_done(merge_done),
    .chg_done(chg_done), .soc_wr_reg(soc_wr_reg), .spi_ce_n(spi_ce_n), .ext_rom_en(ext_rom_en),
    .load_req(load_req), .merge_req(merge_req), .chg_req(chg_req), .suspended(suspended), .phy_oe(phy_oe),
    .pll_run(pll_run), .exec_addr(exec_addr), .fixed_ports(fixed_ports), .charge_ports(charge_ports),
    .ports_en(ports_en), .stage(stage), .fixed_count(fixed_count), .charge_count(charge_count));

/* verif/hbcs_rom_model.sv */
// hbcs_rom_model: behavioural spi boot rom, single-bit read
// assumes mode 0 and that each frame reads the signature word
`timescale 1ns/10ps
module hbcs_rom_model (
    input  wire logic        spi_ce_n, // chip enable, active low
    input  wire logic        spi_sck,  // serial clock
    input  wire logic        spi_do,   // command and address in
    input  wire logic [31:0] sig,      // stored signature word
    output logic             spi_di,   // read data out
    output logic [31:0]      rx_cmd    // command and address seen
);
    logic [31:0] word;
    int          bits = 0;
    initial spi_di = 1'b0;
    // ========================================
    // frame start clears shift state
    always @(negedge spi_ce_n) begin
        bits = 0;
        rx_cmd = 32'h0000_0000;
        word = sig;
    end
    always @(posedge spi_sck) if (!spi_ce_n && bits < 32) begin
        rx_cmd = {rx_cmd[30:0], spi_do};
        bits++;
    end
    // change on the fall so the high half stays stable
    always @(negedge spi_sck) if (!spi_ce_n && bits == 32) begin
        spi_di = word[31];
        word = {word[30:0], 1'b0};
    end
    // released line shows the inverse
    always @(posedge spi_ce_n) spi_di = ~spi_di;
endmodule : hbcs_rom_model

/* verif/hbcs_top_test.sv */
// hbcs_top_test: boots the sequencer once per strap level, both config routes
// assumes the rom model answers single-bit mode 0 reads
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module hbcs_top_test;
    logic        sys_clk, arst_n, chip_reset_n, pull, vbus, connect_req, soft_disc, load_done;
    logic        soc_wr, merge_done, chg_done, spi_di, spi_ce_n, spi_sck, spi_do, ext_rom_en;
    logic        smbus_mode, soc_cfg_en, suspended, usb_connect, phy_oe;
    logic [2:0]  fixed_strap, charge_strap, fixed_count;
    logic [7:0]  soc_wr_reg;
    logic [31:0] sig, rx_cmd;
    logic [15:0] exec_addr;
    logic [3:0]  fixed_ports, charge_ports, ports_en, stage;
    int          n_errors = 0;
    int          compares = 0;
    hbcs_top i_hbcs_top (.sys_clk(sys_clk), .arst_n(arst_n), .chip_reset_n(chip_reset_n),
        .fixed_port_strap(fixed_strap), .charge_port_strap(charge_strap), .sdo_pullup(pull), .sck_pullup(pull),
        .sdo_pulled(pull), .sck_pulled(pull), .spi_dual(1'b0), .spi_mode3(1'b0), .spi_di(spi_di),
        .spi_do_in(1'b0), .vbus(vbus), .connect_req(connect_req), .soft_disc(soft_disc),
        .usb_configured(usb_connect),
        .load_done(load_done), .soc_wr(soc_wr), .soc_wr_reg(soc_wr_reg), .merge_done(merge_done),
        .chg_done(chg_done), .spi_ce_n(spi_ce_n), .spi_sck(spi_sck), .spi_do(spi_do), .spi_do_oe(),
        .ext_rom_en(ext_rom_en), .exec_addr(exec_addr), .load_req(), .fixed_ports(fixed_ports),
        .charge_ports(charge_ports), .fixed_count(fixed_count), .charge_count(), .smbus_mode(smbus_mode),
        .soc_cfg_en(soc_cfg_en), .merge_req(), .chg_req(), .suspended(suspended), .usb_connect(usb_connect),
        .ports_en(ports_en), .phy_oe(phy_oe), .pll_run(), .stage(stage));
    hbcs_rom_model i_hbcs_rom_model (.spi_ce_n(spi_ce_n), .spi_sck(spi_sck), .spi_do(spi_do), .sig(sig),
        .spi_di(spi_di), .rx_cmd(rx_cmd));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ========================================
    // drive 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic summarize();
        if (n_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    // bounded wait; timeout ends the run
    task automatic wait_stage(input logic [3:0] s);
        int k;
        for (k = 0; k < 2000 && stage !== s; k++) tick(1);
        if (k == 2000) begin
            n_errors++;
            summarize();
        end
    endtask : wait_stage
    task automatic soc_write(input logic [7:0] r);
        soc_wr_reg = r;
        soc_wr = 1'b1;
        tick(1);
        soc_wr = 1'b0;
    endtask : soc_write
    // ========================================
    // one boot per level: odd levels via smbus, level 2 bad signature
    initial begin
        {arst_n, chip_reset_n, pull, vbus, connect_req, soft_disc, load_done, soc_wr, merge_done} = '0;
        {chg_done, fixed_strap, charge_strap, soc_wr_reg, sig} = '0;
        tick(2);
        arst_n = 1'b1;
        for (int l = 0; l < 5; l++) begin
            pull = l[0];
            sig = (l == 2) ? 32'h0000_0000 : hbcs_pkg::SIG_VALUE;
            {fixed_strap, charge_strap} = {3'(l), 3'(4 - l)};
            connect_req = 1'b1;
            chip_reset_n = 1'b1;
            wait_stage(4'h2);
            `CHK(ext_rom_en, l == 0 || l == 4)
            `CHK(smbus_mode, pull)
            if (!pull) `CHK(rx_cmd, {hbcs_pkg::CMD_READ, hbcs_pkg::SIG_ADDR})
            load_done = 1'b1;
            wait_stage(4'h3);
            load_done = 1'b0;
            `CHK(fixed_count, 3'(l))
            `CHK(fixed_ports, 4'((5'h01 << l) - 5'h01))
            `CHK(charge_ports, 4'((5'h01 << (4 - l)) - 5'h01))
            tick(1);
            `CHK(stage, pull ? 4'h4 : 4'h5)
            if (pull) begin
                `CHK(soc_cfg_en, 1'b1)
                soc_write(8'hFE);
                tick(5);
                `CHK(stage, 4'h4)
                soc_write(8'hFF);
                `CHK(stage, 4'h5)
            end
            merge_done = 1'b1;
            wait_stage(4'h6);
            merge_done = 1'b0;
            `CHK(ports_en, 4'hF)
            tick(6);
            `CHK(stage, 4'h6)
            connect_req = 1'b0;
            wait_stage(4'h7);
            `CHK(suspended, 1'b1)
            vbus = 1'b1;
            wait_stage(l == 4 ? 4'h9 : 4'h8);
            chg_done = 1'b1;
            wait_stage(4'h9);
            chg_done = 1'b0;
            tick(4);
            `CHK(usb_connect, 1'b1)
            `CHK(stage, 4'hA)
            soft_disc = 1'b1;
            tick(4);
            `CHK(usb_connect, 1'b0)
            `CHK(stage, 4'h9)
            {vbus, soft_disc} = 2'b00;
            wait_stage(4'h6);
            chip_reset_n = 1'b0;
            wait_stage(4'h0);
            `CHK(fixed_ports, 4'h0)
        end
        summarize();
    end
endmodule : hbcs_top_test
